// [rtl/spi_cfg_pkg.sv]
package spi_cfg_pkg;

    // Clock rate and boot time after soft reset.
    localparam int CLK_HZ = 25_000_000;
    localparam int BOOT_TIME_MS = 5;
    localparam int BOOT_CYCLES = BOOT_TIME_MS * (CLK_HZ / 1000);

    // Register addresses on the serial port.
    localparam logic [14:0] ADDR_CONFIG_A = 15'h0000;
    localparam logic [14:0] ADDR_CONFIG_B = 15'h0001;
    localparam logic [14:0] ADDR_POWER = 15'h0002;
    localparam logic [14:0] ADDR_CLASS = 15'h0003;
    localparam logic [14:0] ADDR_INDEX = 15'h0008;

    // Field positions.
    localparam int A_SOFT_RESET = 0;
    localparam int A_LSB_FIRST = 1;
    localparam int A_ADDR_INC = 2;
    localparam int A_ADDR_INC_M = 5;
    localparam int A_LSB_FIRST_M = 6;
    localparam int A_SOFT_RESET_M = 7;
    localparam int B_DP_RESET = 1;
    localparam int INDEX_CH_A = 0;
    localparam int INDEX_CH_B = 1;

    // Values after reset.
    localparam logic LSB_FIRST_RST = 1'b0;
    localparam logic ADDR_INC_RST = 1'b0;
    localparam logic [1:0] INDEX_RST = 2'h3;
    localparam logic [14:0] ADDR_RST = 15'h0000;

    // Frame bit counts.
    localparam logic [3:0] INSTR_LAST = 4'hF;
    localparam logic [3:0] BYTE_LAST = 4'h7;

    typedef enum logic [1:0] {
        PM_NORMAL = 2'b00,
        PM_RESERVED = 2'b01,
        PM_STANDBY = 2'b10,
        PM_DOWN = 2'b11
    } power_mode_t;

    typedef enum logic [1:0] {
        FR_IDLE = 2'b00,
        FR_INSTR = 2'b01,
        FR_DATA = 2'b10,
        FR_HALT = 2'b11
    } frame_state_t;

    // Bit reversal for least significant bit first shifting.
    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++)
            r[i] = v[7 - i];
        return r;
    endfunction

    function automatic logic [15:0] rev16(input logic [15:0] v);
        return {rev8(v[7:0]), rev8(v[15:8])};
    endfunction

endpackage

// [rtl/ch_power_if.sv]
`timescale 1ns/1ps
interface ch_power_if;
    import spi_cfg_pkg::*;
    logic wr_en;
    logic [1:0] wr_sel;
    power_mode_t wr_mode;
    logic soft_rst;
    power_mode_t mode_a;
    power_mode_t mode_b;
    logic [1:0] clocks_en;
    logic [1:0] dp_hold;
    logic [1:0] link_en;
    modport bank (
        output wr_en, wr_sel, wr_mode, soft_rst,
        input mode_a, mode_b, clocks_en, dp_hold, link_en
    );
    modport store (
        input wr_en, wr_sel, wr_mode, soft_rst,
        output mode_a, mode_b, clocks_en, dp_hold, link_en
    );
endinterface

// [rtl/channel_power_store.sv]
`timescale 1ns/1ps
module channel_power_store (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic resetn_i,
    // Link to the register bank.
    ch_power_if.store pw
);
    import spi_cfg_pkg::*;

    power_mode_t mode_d [2];
    power_mode_t mode_q [2];
    logic [1:0] clk_d, hold_d, link_d;
    logic [1:0] clk_q, hold_q, link_q;

    ////////////////////////////////////////////////////////////////////////
    // Each channel keeps its own mode and decoded controls.
    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            mode_d[c] = mode_q[c];
            if (pw.soft_rst)
                mode_d[c] = PM_NORMAL;
            else if (pw.wr_en && pw.wr_sel[c]) // [RULE9]
                mode_d[c] = pw.wr_mode;
            case (mode_d[c]) // [RULE8]
                PM_STANDBY:
                begin
                    clk_d[c] = 1'b0;
                    hold_d[c] = 1'b0;
                    link_d[c] = 1'b1;
                end
                PM_DOWN:
                begin
                    clk_d[c] = 1'b0;
                    hold_d[c] = 1'b1;
                    link_d[c] = 1'b0;
                end
                default:
                begin
                    clk_d[c] = 1'b1;
                    hold_d[c] = 1'b0;
                    link_d[c] = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            mode_q[0] <= PM_NORMAL;
            mode_q[1] <= PM_NORMAL;
            clk_q <= 2'h3;
            hold_q <= 2'h0;
            link_q <= 2'h3;
        end
        else
        begin
            mode_q <= mode_d;
            clk_q <= clk_d;
            hold_q <= hold_d;
            link_q <= link_d;
        end
    end

    assign pw.mode_a = mode_q[0];
    assign pw.mode_b = mode_q[1];
    assign pw.clocks_en = clk_q;
    assign pw.dp_hold = hold_q;
    assign pw.link_en = link_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    mode_split_a: assert property ( // [RULE9]
        pw.wr_en && pw.wr_sel == 2'b10 && !pw.soft_rst
        |=> mode_q[0] == $past(mode_q[0]) && mode_q[1] == $past(pw.wr_mode))
        else $error("Channel B write changed channel A.");
    standby_a: assert property ( // [RULE8]
        mode_q[1] == PM_STANDBY |-> !clk_q[1] && link_q[1] && !hold_q[1])
        else $error("Standby decode wrong.");
    power_down_a: assert property ( // [RULE8]
        mode_q[0] == PM_DOWN |-> !clk_q[0] && hold_q[0] && !link_q[0])
        else $error("Power-down decode wrong.");
    both_wr_c: cover property (pw.wr_en && pw.wr_sel == 2'b11);
endmodule

// [rtl/spi_config_register_bank.sv]
`timescale 1ns/1ps
// Operation
// [RULE1] Host writes only documented register addresses.
// [RULE2] Soft reset bit or mirror resets port, registers.
// [RULE3] Host waits 5 ms after soft reset.
// [RULE4] Shift order bit selects LSB-first shifting.
// [RULE5] Direction bit: increment when 1, else decrement.
// [RULE6] Bits 7,6,5 mirror 0,1,2; 4:3 reserved.
// [RULE7] Datapath reset bit pulses and self clears.
// [RULE8] Power mode: normal, standby, power-down decode.
// [RULE9] Each channel keeps its own power mode.
// [RULE10] Index select bits steer per-channel writes.
// [RULE11] Read with both selects returns channel A.
// [RULE12] Host issues soft reset by writing 0x81.
// [RULE13] Host avoids reserved power mode code 01.
module spi_config_register_bank #(
    parameter int BOOT_CYCLES_P = spi_cfg_pkg::BOOT_CYCLES,
    parameter logic [7:0] CLASS_CODE_P = 8'h5A // Arbitrary value.
) (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic resetn_i,
    // Serial port pins.
    input wire logic sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic sdio_i,
    output logic sdio_o,
    output logic sdio_oe_o,
    // Device controls.
    output logic datapath_reset_o,
    output logic boot_busy_o,
    output logic [1:0] clocks_enable_o,
    output logic [1:0] datapath_hold_o,
    output logic [1:0] link_enable_o
);
    import spi_cfg_pkg::*;

    localparam int BW = $clog2(BOOT_CYCLES_P + 1);

    ch_power_if pw ();

    channel_power_store u_store (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .pw(pw)
    );

    logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
    logic cs_s1_q, cs_s2_q, sdi_s1_q, sdi_s2_q;
    logic rise, fall;
    frame_state_t state_d, state_q;
    logic [3:0] cnt_d, cnt_q;
    logic [15:0] shift_d, shift_q;
    logic [14:0] addr_d, addr_q;
    logic read_d, read_q;
    logic [7:0] tx_d, tx_q;
    logic sdio_d, sdio_q;
    logic lsb_first_d, lsb_first_q;
    logic addr_inc_d, addr_inc_q;
    logic [1:0] index_d, index_q;
    logic dp_rst_d, dp_rst_q;
    logic soft_rst_d, soft_rst_q;
    logic [BW-1:0] boot_d, boot_q;
    logic wr_fire;
    logic [7:0] wr_data;
    logic [15:0] sh;
    logic [15:0] instr;
    logic [14:0] nxt;
    power_mode_t power_view;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and serial clock edges.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_s3_q <= 1'b0;
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            sdi_s1_q <= 1'b0;
            sdi_s2_q <= 1'b0;
        end
        else
        begin
            sclk_s1_q <= sclk_i;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
            cs_s1_q <= spi_cs_n_i;
            cs_s2_q <= cs_s1_q;
            sdi_s1_q <= sdio_i;
            sdi_s2_q <= sdi_s1_q;
        end
    end

    assign rise = sclk_s2_q && !sclk_s3_q;
    assign fall = !sclk_s2_q && sclk_s3_q;

    ////////////////////////////////////////////////////////////////////////
    // Read view of the register map.
    assign power_view = index_q[INDEX_CH_A] ? pw.mode_a : pw.mode_b; // [RULE11]

    function automatic logic [7:0] rd_byte(input logic [14:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            ADDR_CONFIG_A:
            begin
                v[A_LSB_FIRST] = lsb_first_q; // [RULE6]
                v[A_LSB_FIRST_M] = lsb_first_q;
                v[A_ADDR_INC] = addr_inc_q;
                v[A_ADDR_INC_M] = addr_inc_q;
            end
            ADDR_POWER: v[1:0] = power_view;
            ADDR_CLASS: v = CLASS_CODE_P;
            ADDR_INDEX: v[1:0] = index_q;
            default: v = 8'h00;
        endcase
        return lsb_first_q ? rev8(v) : v; // [RULE4]
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Frame engine and register writes.
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        addr_d = addr_q;
        read_d = read_q;
        tx_d = tx_q;
        sdio_d = sdio_q;
        lsb_first_d = lsb_first_q;
        addr_inc_d = addr_inc_q;
        index_d = index_q;
        dp_rst_d = 1'b0;
        soft_rst_d = 1'b0;
        boot_d = (boot_q != '0) ? boot_q - 1'b1 : boot_q;
        wr_fire = 1'b0;
        wr_data = 8'h00;
        pw.wr_en = 1'b0;
        pw.wr_sel = index_q; // [RULE10]
        pw.wr_mode = PM_NORMAL;
        sh = {shift_q[14:0], sdi_s2_q};
        instr = lsb_first_q ? rev16(sh) : sh; // [RULE4]
        nxt = addr_inc_q ? addr_q + 15'h0001 : addr_q - 15'h0001; // [RULE5]
        case (state_q)
            FR_IDLE:
            begin
                cnt_d = 4'h0;
                if (!cs_s2_q)
                    state_d = FR_INSTR;
            end
            FR_INSTR:
            begin
                if (rise)
                begin
                    shift_d = sh;
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == INSTR_LAST)
                    begin
                        read_d = instr[15];
                        addr_d = instr[14:0];
                        tx_d = rd_byte(instr[14:0]);
                        cnt_d = 4'h0;
                        state_d = FR_DATA;
                    end
                end
            end
            FR_DATA:
            begin
                if (rise)
                begin
                    shift_d = sh;
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == BYTE_LAST)
                    begin
                        cnt_d = 4'h0;
                        wr_fire = !read_q;
                        wr_data = lsb_first_q ? rev8(sh[7:0]) : sh[7:0];
                        addr_d = nxt; // [RULE5]
                        tx_d = rd_byte(nxt);
                    end
                end
                else if (fall && read_q)
                begin
                    sdio_d = tx_q[7];
                    tx_d = {tx_q[6:0], 1'b0};
                end
            end
            FR_HALT: cnt_d = 4'h0;
            default: state_d = FR_IDLE;
        endcase
        if (wr_fire)
        begin
            case (addr_q)
                ADDR_CONFIG_A:
                begin
                    soft_rst_d = wr_data[A_SOFT_RESET]
                        || wr_data[A_SOFT_RESET_M]; // [RULE2]
                    lsb_first_d = wr_data[A_LSB_FIRST]
                        || wr_data[A_LSB_FIRST_M]; // [RULE6]
                    addr_inc_d = wr_data[A_ADDR_INC]
                        || wr_data[A_ADDR_INC_M]; // [RULE6]
                end
                ADDR_CONFIG_B: dp_rst_d = wr_data[B_DP_RESET]; // [RULE7]
                ADDR_POWER:
                begin
                    pw.wr_en = 1'b1; // [RULE10]
                    pw.wr_mode = power_mode_t'(wr_data[1:0]);
                end
                ADDR_INDEX: index_d = wr_data[1:0];
                default: index_d = index_q;
            endcase
        end
        if (soft_rst_q) // [RULE2]
        begin
            lsb_first_d = LSB_FIRST_RST;
            addr_inc_d = ADDR_INC_RST;
            index_d = INDEX_RST;
            addr_d = ADDR_RST;
            read_d = 1'b0;
            state_d = FR_HALT;
            boot_d = BW'(BOOT_CYCLES_P);
        end
        if (cs_s2_q)
            state_d = FR_IDLE;
        pw.soft_rst = soft_rst_q;
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_q <= FR_IDLE;
            cnt_q <= 4'h0;
            shift_q <= 16'h0000;
            addr_q <= ADDR_RST;
            read_q <= 1'b0;
            tx_q <= 8'h00;
            sdio_q <= 1'b0;
            lsb_first_q <= LSB_FIRST_RST;
            addr_inc_q <= ADDR_INC_RST;
            index_q <= INDEX_RST;
            dp_rst_q <= 1'b0;
            soft_rst_q <= 1'b0;
            boot_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            addr_q <= addr_d;
            read_q <= read_d;
            tx_q <= tx_d;
            sdio_q <= sdio_d;
            lsb_first_q <= lsb_first_d;
            addr_inc_q <= addr_inc_d;
            index_q <= index_d;
            dp_rst_q <= dp_rst_d;
            soft_rst_q <= soft_rst_d;
            boot_q <= boot_d;
        end
    end

    assign sdio_o = sdio_q;
    assign sdio_oe_o = (state_q == FR_DATA) && read_q && !cs_s2_q;
    assign datapath_reset_o = dp_rst_q;
    assign boot_busy_o = (boot_q != '0);
    assign clocks_enable_o = pw.clocks_en;
    assign datapath_hold_o = pw.dp_hold;
    assign link_enable_o = pw.link_en;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    soft_trig_a: assert property ( // [RULE2]
        wr_fire && addr_q == ADDR_CONFIG_A && (wr_data[0] || wr_data[7])
        |=> soft_rst_q ##1 !soft_rst_q && !lsb_first_q && !addr_inc_q
            && index_q == INDEX_RST && boot_busy_o)
        else $error("Soft reset did not restore defaults.");
    lsb_mirror_a: assert property ( // [RULE4]
        wr_fire && addr_q == ADDR_CONFIG_A && !soft_rst_q
        |=> lsb_first_q == ($past(wr_data[1]) || $past(wr_data[6])))
        else $error("Shift order bit not taken from bit or mirror.");
    inc_mirror_a: assert property ( // [RULE6]
        wr_fire && addr_q == ADDR_CONFIG_A && !soft_rst_q
        |=> addr_inc_q == ($past(wr_data[2]) || $past(wr_data[5])))
        else $error("Direction bit not taken from bit or mirror.");
    addr_step_a: assert property ( // [RULE5]
        state_q == FR_DATA && rise && cnt_q == BYTE_LAST && !cs_s2_q
        && !soft_rst_q && addr_inc_q |=> addr_q == $past(addr_q) + 15'h0001)
        else $error("Address did not increment.");
    dp_pulse_a: assert property ( // [RULE7]
        wr_fire && addr_q == ADDR_CONFIG_B && wr_data[1]
        |=> datapath_reset_o ##1 !datapath_reset_o)
        else $error("Datapath reset not a single pulse.");
    power_route_a: assert property ( // [RULE10]
        wr_fire && addr_q == ADDR_POWER
        |-> pw.wr_en && pw.wr_sel == index_q)
        else $error("Power write not steered by index.");
    read_pick_a: assert property ( // [RULE11]
        index_q == 2'b11 |-> power_view == pw.mode_a)
        else $error("Dual select read did not return channel A.");

    soft_reset_c: cover property (soft_rst_q);
    read_frame_c: cover property (sdio_oe_o && fall);
    power_both_c: cover property (pw.wr_en && index_q == 2'b11);
endmodule

// [verif/spi_host_model.sv]
`timescale 1ns/1ps
module spi_host_model (
    // Clock.
    input wire logic clock_i,
    // Serial port pins.
    output logic sclk_o,
    output logic spi_cs_n_o,
    output logic sdio_o,
    input wire logic dev_sdio_i,
    input wire logic dev_sdio_oe_i
);
    logic lsb_first;
    logic drive;
    logic bit_q;
    logic filler_q;

    initial
    begin
        sclk_o = 1'b0;
        spi_cs_n_o = 1'b1;
        drive = 1'b0;
        bit_q = 1'b0;
        filler_q = 1'b0;
        lsb_first = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // A released line shows a pattern that changes every cycle.
    always @(posedge clock_i)
        filler_q <= ~filler_q;

    assign sdio_o = dev_sdio_oe_i ? dev_sdio_i : (drive ? bit_q : filler_q);

    ////////////////////////////////////////////////////////////////////////
    task automatic wait_low(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    // One bit: data changes with the falling serial clock.
    task automatic bit_cycle(input logic b, input logic drv,
        output logic got);
        sclk_o = 1'b0;
        drive = drv;
        bit_q = b;
        wait_low(6);
        got = sdio_o;
        sclk_o = 1'b1;
        wait_low(6);
    endtask

    // Instruction, then n bytes written from wr or read into got_q.
    task automatic frame(input logic rd, input logic [14:0] addr,
        input logic [7:0] wr[$], input int n, output logic [7:0] got_q[$]);
        logic [15:0] ins;
        logic [7:0] by;
        logic g;
        got_q = {};
        ins = {rd, addr};
        @(negedge clock_i);
        spi_cs_n_o = 1'b0;
        wait_low(4);
        for (int i = 0; i < 16; i++)
            bit_cycle(ins[lsb_first ? i : 15 - i], 1'b1, g);
        for (int k = 0; k < n; k++)
        begin
            by = rd ? 8'h00 : wr[k];
            for (int i = 0; i < 8; i++)
            begin
                bit_cycle(by[lsb_first ? i : 7 - i], !rd, g);
                by[lsb_first ? i : 7 - i] = g;
            end
            got_q.push_back(by);
        end
        sclk_o = 1'b0;
        drive = 1'b0;
        wait_low(4);
        spi_cs_n_o = 1'b1;
        wait_low(8);
    endtask
endmodule

// [verif/test_spi_config_register_bank.sv]
`timescale 1ns/1ps
module test_spi_config_register_bank;
    import spi_cfg_pkg::*;

    localparam int BOOT_P = 20;
    localparam logic [7:0] CLASS_P = 8'h3C; // Arbitrary value.

    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic sclk;
    logic cs_n;
    logic sdio_line;
    logic sdio_out;
    logic sdio_oe;
    logic dp_reset;
    logic boot_busy;
    logic [1:0] clk_en;
    logic [1:0] hold;
    logic [1:0] link_en;
    logic [7:0] pwr;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int dp_count = 0;
    int busy_count = 0;
    logic [7:0] wq[$];
    logic [7:0] rq[$];
    logic [7:0] none_q[$];

    assign pwr = {2'b00, clk_en, hold, link_en};

    always #20 clock_i = ~clock_i;

    spi_config_register_bank #(
        .BOOT_CYCLES_P(BOOT_P),
        .CLASS_CODE_P(CLASS_P)
    ) u_spi_config_register_bank (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .sclk_i(sclk),
        .spi_cs_n_i(cs_n),
        .sdio_i(sdio_line),
        .sdio_o(sdio_out),
        .sdio_oe_o(sdio_oe),
        .datapath_reset_o(dp_reset),
        .boot_busy_o(boot_busy),
        .clocks_enable_o(clk_en),
        .datapath_hold_o(hold),
        .link_enable_o(link_en)
    );

    spi_host_model u_spi_host_model (
        .clock_i(clock_i),
        .sclk_o(sclk),
        .spi_cs_n_o(cs_n),
        .sdio_o(sdio_line),
        .dev_sdio_i(sdio_out),
        .dev_sdio_oe_i(sdio_oe)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clock_i)
    begin
        cycles++;
        if (dp_reset === 1'b1)
            dp_count++;
        if (boot_busy === 1'b1)
            busy_count++;
        if (cycles == 60000)
        begin
            errors++;
            $display("unexpected at %0t: run hung", $time);
            conclude();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
        input string what);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what,
                seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [14:0] a, input logic [7:0] d);
        wq = {d};
        u_spi_host_model.frame(1'b0, a, wq, 1, rq);
    endtask

    task automatic rd_chk(input logic [14:0] a, input logic [7:0] e,
        input string what);
        u_spi_host_model.frame(1'b1, a, none_q, 1, rq);
        check(rq[0], e, what);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check(pwr, 8'h33, "reset power");
        check({6'h00, boot_busy, dp_reset}, 8'h00, "reset flags");
        rd_chk(ADDR_CLASS, CLASS_P, "class code");
        rd_chk(ADDR_CONFIG_A, 8'h00, "a reset");
        rd_chk(ADDR_CONFIG_B, 8'h00, "b reset");
        rd_chk(15'h0010, 8'h00, "unmapped");
    endtask

    task automatic t_power();
        logic [1:0] modes [3];
        logic [1:0] m;
        logic [7:0] e;
        modes = '{2'b00, 2'b10, 2'b11};
        wr_reg(ADDR_INDEX, 8'h01);
        for (int i = 0; i < 3; i++)
        begin
            m = modes[i];
            wr_reg(ADDR_POWER, {6'h00, m});
            e = {3'b001, ~m[1], 1'b0, m == 2'b11, 1'b1, m != 2'b11};
            check(pwr, e, "mode a");
            rd_chk(ADDR_POWER, {6'h00, m}, "mode read");
        end
        wr_reg(ADDR_INDEX, 8'h02);
        wr_reg(ADDR_POWER, 8'h02);
        check(pwr, 8'h06, "mode b");
        rd_chk(ADDR_POWER, 8'h02, "read b");
        wr_reg(ADDR_INDEX, 8'h03);
        rd_chk(ADDR_POWER, 8'h03, "read both");
        wr_reg(ADDR_POWER, 8'h00);
        check(pwr, 8'h33, "both normal");
    endtask

    task automatic t_dp();
        dp_count = 0;
        wr_reg(ADDR_CONFIG_B, 8'h02);
        check(dp_count[7:0], 8'h01, "dp pulse");
        check(pwr, 8'h33, "dp power kept");
        rd_chk(ADDR_CONFIG_B, 8'h00, "b self clear");
    endtask

    task automatic t_shift();
        wr_reg(ADDR_CONFIG_A, 8'h02);
        u_spi_host_model.lsb_first = 1'b1;
        rd_chk(ADDR_CONFIG_A, 8'h42, "lsb mirror");
        rd_chk(ADDR_CLASS, CLASS_P, "lsb class");
        wr_reg(ADDR_CONFIG_A, 8'h40);
        rd_chk(ADDR_CONFIG_A, 8'h42, "lsb by mirror");
        wr_reg(ADDR_CONFIG_A, 8'h00);
        u_spi_host_model.lsb_first = 1'b0;
        rd_chk(ADDR_CONFIG_A, 8'h00, "msb again");
    endtask

    task automatic t_direction();
        wr_reg(ADDR_POWER, 8'h02);
        u_spi_host_model.frame(1'b1, ADDR_CLASS, none_q, 2, rq);
        check(rq[0], CLASS_P, "dec first");
        check(rq[1], 8'h02, "dec second");
        wr_reg(ADDR_CONFIG_A, 8'h20);
        rd_chk(ADDR_CONFIG_A, 8'h24, "inc mirror");
        wq = {8'h00, 8'h03};
        u_spi_host_model.frame(1'b0, ADDR_CONFIG_B, wq, 2, rq);
        check(pwr, 8'h0C, "inc write");
        wr_reg(ADDR_POWER, 8'h00);
        wr_reg(ADDR_CONFIG_A, 8'h00);
    endtask

    task automatic t_soft();
        logic [7:0] codes [3];
        codes = '{8'h81, 8'h80, 8'h01};
        for (int i = 0; i < 3; i++)
        begin
            wr_reg(ADDR_POWER, 8'h03);
            wr_reg(ADDR_CONFIG_A, 8'h24);
            dp_count = 0;
            busy_count = 0;
            wq = {codes[i], 8'h02};
            u_spi_host_model.frame(1'b0, ADDR_CONFIG_A, wq, 2, rq);
            while (boot_busy !== 1'b0)
                @(negedge clock_i);
            check(busy_count[7:0], BOOT_P[7:0], "boot time");
            check(dp_count[7:0], 8'h00, "frame ignored");
            check(pwr, 8'h33, "power default");
            rd_chk(ADDR_CONFIG_A, 8'h00, "a default");
            rd_chk(ADDR_INDEX, 8'h03, "index default");
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(negedge clock_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge clock_i);
        t_reset();
        t_power();
        t_dp();
        t_shift();
        t_direction();
        t_soft();
        conclude();
    end
endmodule
